// ==== hw/pvtwd_decode.sv ====
// pci target window decode and translation toward the far bus
//
// Summary of operation
// R01: eight standard 32-bit windows; windows 0 and 4 4KB, others 64KB granular
// R02: claim only inside base..limit, in chosen space, with a fitting command
// R03: far address is pci address plus the window translation offset
// R04: sums past 4GB wrap into the low range
// R05: modifier code and cycle type follow the window settings
// R06: invalid setting combinations are issued as programmed, never blocked
// R07: two custom codes, held only within 0x10..0x1f
// R08: custom code selection gives single cycles, 32-bit width, other settings ignored
// R09: block select honoured only for A24/A32 with 8/16/32 width
// R10: A24/A32 with 64-bit width may give multiplexed block transfers
// R11: posted, width 16+, no block: burst 0011 then 1100 splits into 16-bit; code splits the pair only with address bit 2 clear
// R12: 64-bit posted write with enables 11000011 also splits into 16-bit
// R13: posting enable makes writes complete as posted
// R14: only memory windows post; i/o decodes stay coupled
// R15: attributes captured at claim stay with that transaction
// R16: software waits for an empty outbound queue before changing settings
// R17: fixed window decodes address 31..26 against a 6-bit base, 64MB
// R18: fixed window splits into four 16MB regions by address 25..24
// R19: top 64KB of each region maps to A16, the rest to A24
// R20: fixed window applies no offset
// R21: each region has its own width, privilege and program/data choice
// R22: fixed window has one enable and one posting enable
// R23: disabled windows never claim; no match leaves the cycle unclaimed
`timescale 1ns/1ns
`default_nettype none
module pvtwd_decode (
  // clock and reset
  input wire logic MCLK,
  input wire logic RESET_N,
  // pci address phase
  input wire logic ADDR_VALID,
  input wire pvtwd_pkg::pvtwd_pci_s PCI_ADDR,
  // pci data phase
  input wire logic DATA_VALID,
  input wire logic [7:0] DATA_BE_N,
  input wire logic DATA_IS64,
  input wire logic DATA_LAST,
  // register port
  input wire logic REG_WR,
  input wire logic [5:0] REG_IDX,
  input wire logic [31:0] REG_WDATA,
  output logic [31:0] REG_RDATA,
  // decode result
  output logic CLAIM,
  output logic MISS,
  output pvtwd_pkg::pvtwd_req_s REQ,
  output logic SPLIT16
);
  import pvtwd_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE = 4'b0001, S_FIRST = 4'b0010, S_LOW = 4'b0100, S_REST = 4'b1000
  } pvtwd_state_e;

  logic [31:0] win_r [0:4*NWIN-1];
  logic [31:0] custom_r;
  logic [31:0] fixed_r;
  logic [31:0] rdata_r;
  logic claim_r, miss_r, split_r, split_ok_r;
  pvtwd_req_s req_r;
  pvtwd_state_e state_r, state_nxt;

  // command fits the window's near space
  function automatic logic cmd_ok(input logic io, input logic [3:0] c);
    if (io) begin
      return (c == CMD_IO_RD) || (c == CMD_IO_WR);
    end
    return (c == CMD_MEM_RD) || (c == CMD_MEM_WR) || (c == CMD_MEM_RDM) ||
           (c == CMD_MEM_RDL) || (c == CMD_MEM_WRI);
  endfunction

  function automatic logic is_write(input logic [3:0] c);
    return (c == CMD_IO_WR) || (c == CMD_MEM_WR) || (c == CMD_MEM_WRI);
  endfunction

  // modifier code from space, privilege, program select and cycle kind
  function automatic logic [5:0] am_code(input pvtwd_space_e sp, input logic sup,
      input logic prog, input logic blt, input logic mb);
    logic [1:0] lo;
    lo = mb ? AM_MBLT : (blt ? AM_BLT : (prog ? AM_PROG : AM_DATA));
    if (sp == VS_A32) begin
      return {AM_A32_HI, sup, lo};
    end else if (sp == VS_A24) begin
      return {AM_A24_HI, sup, lo};
    end else if (sp == VS_CRCSR) begin
      return AM_CRCSR;
    end
    // a16 has no program space or block codes, data code only
    return {AM_A16_HI, sup, AM_DATA};
  endfunction

  // per-window match; granularity is applied to both sides of the compare
  // limit is exclusive, so a window with base equal to limit never claims
  wire [NWIN-1:0] win_hit;
  for (genvar g = 0; g < NWIN; g++) begin : g_win
    wire [31:0] msk = (g == 0 || g == 4) ? FINE_MASK : COARSE_MASK; // [R01]
    wire [31:0] ctl = win_r[4*g+3];
    wire [31:0] am = PCI_ADDR.addr & msk;
    assign win_hit[g] = ctl[CTL_EN] && (am >= (win_r[4*g] & msk)) && // [R23]
                        (am < (win_r[4*g+1] & msk)) &&               // [R02]
                        cmd_ok(ctl[CTL_NEAR_IO], PCI_ADDR.cmd);
  end

  // lowest numbered hit wins when windows overlap
  // a window fully hidden behind a lower one is unreachable, not an error
  logic [2:0] sel;
  always_comb begin
    sel = 3'h0;
    for (int i = NWIN - 1; i >= 0; i--) begin
      if (win_hit[i]) begin
        sel = i[2:0];
      end
    end
  end

  // standard window translation and attributes
  wire [1:0] sb = (sel == 3'h0 || sel == 3'h4) ? 2'h0 : 2'h1;
  wire [31:0] s_msk = (sb == 2'h0) ? FINE_MASK : COARSE_MASK;
  wire [31:0] s_ctl = win_r[{sel, 2'h3}];
  wire [31:0] s_off = win_r[{sel, 2'h2}] & s_msk;
  wire [31:0] s_addr = PCI_ADDR.addr + s_off; // [R03] [R04] carry drops: wraps
  wire pvtwd_space_e s_sp = pvtwd_space_e'(s_ctl[CTL_FAR_LO +: 3]);
  wire pvtwd_width_e s_w = pvtwd_width_e'(s_ctl[CTL_WIDTH_LO +: 2]);
  wire s_a2432 = (s_sp == VS_A24) || (s_sp == VS_A32);
  wire s_user = (s_sp == VS_CUSTOM_CODE_ONE) || (s_sp == VS_CUSTOM_CODE_TWO);
  wire s_blk = s_a2432 && (s_w != W64) && s_ctl[CTL_BLOCK]; // [R09]
  wire s_mb = s_a2432 && (s_w == W64); // [R10]
  wire [5:0] s_ucode = (s_sp == VS_CUSTOM_CODE_ONE) ? custom_r[CU_ONE_LO +: 6]
                                          : custom_r[CU_TWO_LO +: 6];
  // other combinations pass straight to the code builder unchecked
  wire [5:0] s_am = s_user ? s_ucode : // [R08]
      am_code(s_sp, s_ctl[CTL_SUPER], s_ctl[CTL_PROG], s_blk, s_mb); // [R05] [R06]
  wire s_post = s_ctl[CTL_POST] && !s_ctl[CTL_NEAR_IO] && // [R13] [R14]
                is_write(PCI_ADDR.cmd);

  // fixed window decode
  wire [1:0] rg = PCI_ADDR.addr[25:24]; // [R18]
  wire f_hit = fixed_r[FX_EN] && // [R22]
      (PCI_ADDR.addr[31:26] == fixed_r[FX_BASE_LO +: 6]) && // [R17]
      cmd_ok(fixed_r[FX_NEAR_IO], PCI_ADDR.cmd);
  // the a16 share is the top 64KB of each region, so four a16 spaces exist
  wire f_a16 = PCI_ADDR.addr[23:16] == FX_A16_TOP; // [R19]
  wire [31:0] f_addr = f_a16 ? {16'h0, PCI_ADDR.addr[15:0]}
                             : {8'h0, PCI_ADDR.addr[23:0]}; // [R20]
  wire [5:0] f_am = am_code(f_a16 ? VS_A16 : VS_A24, // [R21]
      fixed_r[FX_SUPER_LO + rg], fixed_r[FX_PROG_LO + rg], 1'b0, 1'b0);
  wire pvtwd_width_e f_w = fixed_r[FX_WIDTH_LO + rg] ? W32 : W16;
  wire f_post = fixed_r[FX_POST] && !fixed_r[FX_NEAR_IO] && is_write(PCI_ADDR.cmd);

  // merged result; standard windows take priority over the fixed one
  wire any_std = |win_hit;
  wire hit = any_std || f_hit; // [R23]
  pvtwd_req_s dec;
  always_comb begin
    dec.addr = any_std ? s_addr : f_addr;
    dec.am = any_std ? s_am : f_am;
    dec.width = any_std ? (s_user ? W32 : s_w) : f_w;
    dec.block = any_std && !s_user && s_blk;
    dec.mblt = any_std && !s_user && s_mb;
    dec.posted = any_std ? s_post : f_post;
    dec.special = !any_std;
    dec.win = sel;
  end
  // 0011-then-1100 pair splitting is possible only for posted, non-block, 16-bit-or-wider
  wire dec_split = dec.posted && (dec.width != W8) && // [R11]
      !(any_std && !s_user && s_ctl[CTL_BLOCK]) && !PCI_ADDR.addr[2];

  // decode result register; claim and miss last one cycle, the request is held until the next claim
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      claim_r <= 1'b0;
      miss_r <= 1'b0;
      req_r <= '0;
      split_ok_r <= 1'b0;
    end else begin
      claim_r <= ADDR_VALID && hit;
      miss_r <= ADDR_VALID && !hit;
      if (ADDR_VALID && hit) begin
        req_r <= dec; // [R15] snapshot, later setting edits do not touch it
        split_ok_r <= dec_split;
      end
    end
  end

  // data phase pattern tracker for 16-bit splitting
  wire be_lo = !DATA_IS64 && (DATA_BE_N[3:0] == BE_LOW_PAIR);
  wire be_hi = !DATA_IS64 && (DATA_BE_N[3:0] == BE_HIGH_PAIR);
  wire be64 = DATA_IS64 && (DATA_BE_N == BE64_SPLIT);
  wire split_nxt = DATA_VALID && (state_r != S_IDLE) && !ADDR_VALID &&
      ((state_r == S_LOW && be_hi) || (be64 && req_r.posted)); // [R11] [R12]
  // next tracker state; a new address phase overrides any beat in flight
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      S_IDLE: state_nxt = S_IDLE;
      S_FIRST: begin
        if (DATA_VALID) begin
          state_nxt = (be_lo && split_ok_r) ? S_LOW : S_REST;
        end
      end
      S_LOW: begin
        if (DATA_VALID) begin
          state_nxt = S_REST;
        end
      end
      default: state_nxt = S_REST;
    endcase
    if (DATA_VALID && DATA_LAST) begin
      state_nxt = S_IDLE;
    end
    if (ADDR_VALID) begin
      state_nxt = (hit && is_write(PCI_ADDR.cmd)) ? S_FIRST : S_IDLE;
    end
  end
  // tracker state and the one-cycle split pulse
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      state_r <= S_IDLE;
      split_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      split_r <= split_nxt;
    end
  end

  // register writes; custom codes keep the user prefix whatever is written
  wire [31:0] cu_wr = {REG_WDATA[31:14], CU_PREFIX, REG_WDATA[CU_ONE_LO +: 4],
      REG_WDATA[7:6], CU_PREFIX, REG_WDATA[CU_TWO_LO +: 4]}; // [R07]
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      for (int i = 0; i < 4 * NWIN; i++) begin
        win_r[i] <= REG_RST;
      end
      custom_r <= {18'h0, CU_PREFIX, 6'h0, CU_PREFIX, 4'h0}; // [R07]
      fixed_r <= REG_RST;
    end else if (REG_WR) begin
      // changing settings with posted data queued is software's hazard [R16]
      if (REG_IDX < IDX_CUSTOM) begin
        win_r[REG_IDX[4:0]] <= REG_WDATA;
      end else if (REG_IDX == IDX_CUSTOM) begin
        custom_r <= cu_wr;
      end else if (REG_IDX == IDX_FIXED) begin
        fixed_r <= REG_WDATA;
      end
    end
  end

  // read back; status shows the last captured decode and tracker state
  wire [31:0] status = {24'h0, state_r != S_IDLE, req_r.posted, req_r.special,
                        claim_r, 1'b0, req_r.win};
  wire [31:0] rd_nxt = (REG_IDX < IDX_CUSTOM) ? win_r[REG_IDX[4:0]] :
                       (REG_IDX == IDX_CUSTOM) ? custom_r :
                       (REG_IDX == IDX_FIXED) ? fixed_r :
                       (REG_IDX == IDX_STATUS) ? status : 32'h0;
  // registered read data, answering one cycle after the index is seen
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      rdata_r <= REG_RST;
    end else begin
      rdata_r <= rd_nxt;
    end
  end

  assign REG_RDATA = rdata_r;
  assign CLAIM = claim_r;
  assign MISS = miss_r;
  assign REQ = req_r;
  assign SPLIT16 = split_r;

  // checks
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESET_N);

  a_claim_cause: assert property (CLAIM |-> $past(ADDR_VALID && hit)) // [R02]
    else $error("claim without a matching window");
  a_no_enable_miss: assert property (ADDR_VALID && !(|win_hit) && // [R23]
      !fixed_r[FX_EN] |=> MISS && !CLAIM)
    else $error("disabled windows claimed a cycle");
  a_offset_wrap: assert property (ADDR_VALID && any_std |=> // [R04]
      REQ.addr == $past(PCI_ADDR.addr + s_off))
    else $error("translated address wrong");
  a_io_coupled: assert property (CLAIM && $past(PCI_ADDR.cmd) == CMD_IO_WR // [R14]
      |-> !REQ.posted)
    else $error("i/o access was posted");
  a_custom_prefix: assert property (custom_r[CU_ONE_LO + 4 +: 2] == CU_PREFIX && // [R07]
      custom_r[CU_TWO_LO + 4 +: 2] == CU_PREFIX)
    else $error("custom code left its range");
  a_block_gate: assert property (CLAIM && REQ.block |-> // [R09]
      REQ.am[5:3] != AM_A16_HI && REQ.width != W64)
    else $error("block cycle outside A24/A32");
  a_fixed_a16: assert property (ADDR_VALID && f_hit && !any_std && f_a16 // [R19]
      |=> REQ.special && REQ.am[5:3] == AM_A16_HI && REQ.addr[31:16] == 16'h0)
    else $error("fixed window top not in A16");
  a_attr_hold: assert property (!ADDR_VALID ##1 !ADDR_VALID |-> // [R15]
      $stable(REQ))
    else $error("captured attributes changed");
  a_split_pair: assert property (SPLIT16 && !$past(be64) |-> // [R11]
      $past(state_r == S_LOW && be_hi))
    else $error("split without 0011 then 1100");
  a_split64: assert property (DATA_VALID && be64 && req_r.posted && // [R12]
      state_r != S_IDLE && !ADDR_VALID |=> SPLIT16)
    else $error("64-bit split missed");

  // claim and miss never coincide; a miss leaves the held request alone
  a_one_result: assert property (!(CLAIM && MISS)) // [R02]
    else $error("claim and miss together");
  a_miss_holds: assert property (MISS |-> $stable(REQ)) // [R23]
    else $error("a miss changed the held request");

  // custom selections carry a stored code on a plain single 32-bit cycle
  a_custom_single: assert property (CLAIM && REQ.am[5:4] == CU_PREFIX |-> // [R08]
      REQ.width == W32 && !REQ.block && !REQ.mblt)
    else $error("custom code with a block or narrow cycle");
  a_custom_code: assert property (CLAIM && REQ.am[5:4] == CU_PREFIX |-> // [R07]
      REQ.am == $past(custom_r[CU_ONE_LO +: 6]) || REQ.am == $past(custom_r[CU_TWO_LO +: 6]))
    else $error("custom code not the stored one");

  // multiplexed block cycles only on 64-bit A24/A32 windows
  a_mblt_gate: assert property (CLAIM && REQ.mblt |-> // [R10]
      REQ.width == W64 && REQ.am[1:0] == AM_MBLT && !REQ.block)
    else $error("multiplexed block cycle on a narrow window");

  // fixed window: address passes through, per-region width and privilege
  a_fixed_direct: assert property (ADDR_VALID && f_hit && !any_std && !f_a16 |=> // [R20]
      REQ.addr == {8'h0, $past(PCI_ADDR.addr[23:0])})
    else $error("fixed window address altered");
  a_fixed_width: assert property (CLAIM && REQ.special |-> // [R21]
      REQ.width == W16 || REQ.width == W32)
    else $error("fixed window width out of range");
  a_fixed_region: assert property (ADDR_VALID && f_hit && !any_std |=> // [R18]
      REQ.am[2] == $past(fixed_r[FX_SUPER_LO + rg]))
    else $error("fixed window region privilege wrong");

  // covers for the main scenarios
  c_std_claim: cover property (CLAIM && !REQ.special);
  c_fixed_claim: cover property (CLAIM && REQ.special);
  c_split_burst: cover property (state_r == S_LOW ##1 SPLIT16);
  c_miss: cover property (MISS);
  c_mblt_claim: cover property (CLAIM && REQ.mblt);
endmodule
`default_nettype wire

// ==== hw/pvtwd_pkg.sv ====
// shared constants and carrier types for the pci target window decoder
package pvtwd_pkg;
  localparam int NWIN = 8;
  // register indices on the register port, four per standard window
  localparam logic [5:0] IDX_BASE = 6'h00;
  localparam logic [5:0] IDX_LIMIT = 6'h01;
  localparam logic [5:0] IDX_OFFSET = 6'h02;
  localparam logic [5:0] IDX_CTRL = 6'h03;
  localparam logic [5:0] IDX_CUSTOM = 6'h20;
  localparam logic [5:0] IDX_FIXED = 6'h21;
  localparam logic [5:0] IDX_STATUS = 6'h22;
  localparam logic [31:0] REG_RST = 32'h0000_0000;
  // window_control_reg fields
  localparam int CTL_EN = 31;
  localparam int CTL_POST = 30;
  localparam int CTL_WIDTH_LO = 22;
  localparam int CTL_FAR_LO = 16;
  localparam int CTL_PROG = 14;
  localparam int CTL_SUPER = 12;
  localparam int CTL_BLOCK = 8;
  localparam int CTL_NEAR_IO = 0;
  // fixed_window_reg fields, per-region bits are 4 wide
  localparam int FX_EN = 31;
  localparam int FX_POST = 30;
  localparam int FX_WIDTH_LO = 20;
  localparam int FX_PROG_LO = 12;
  localparam int FX_SUPER_LO = 8;
  localparam int FX_NEAR_IO = 6;
  localparam int FX_BASE_LO = 0;
  localparam logic [7:0] FX_A16_TOP = 8'hff;
  // custom_modifier_codes fields
  localparam int CU_ONE_LO = 8;
  localparam int CU_TWO_LO = 0;
  localparam logic [1:0] CU_PREFIX = 2'h1;
  // granularity masks
  localparam logic [31:0] FINE_MASK = 32'hffff_f000;
  localparam logic [31:0] COARSE_MASK = 32'hffff_0000;
  // pci commands
  localparam logic [3:0] CMD_IO_RD = 4'h2;
  localparam logic [3:0] CMD_IO_WR = 4'h3;
  localparam logic [3:0] CMD_MEM_RD = 4'h6;
  localparam logic [3:0] CMD_MEM_WR = 4'h7;
  localparam logic [3:0] CMD_MEM_RDM = 4'hc;
  localparam logic [3:0] CMD_MEM_RDL = 4'he;
  localparam logic [3:0] CMD_MEM_WRI = 4'hf;
  // byte enable patterns (active low) that trigger 16-bit splitting
  localparam logic [3:0] BE_LOW_PAIR = 4'h3;
  localparam logic [3:0] BE_HIGH_PAIR = 4'hc;
  localparam logic [7:0] BE64_SPLIT = 8'hc3;
  // modifier code building blocks
  localparam logic [2:0] AM_A32_HI = 3'h1;
  localparam logic [2:0] AM_A24_HI = 3'h7;
  localparam logic [2:0] AM_A16_HI = 3'h5;
  localparam logic [5:0] AM_CRCSR = 6'h2f;
  localparam logic [1:0] AM_MBLT = 2'h0;
  localparam logic [1:0] AM_DATA = 2'h1;
  localparam logic [1:0] AM_PROG = 2'h2;
  localparam logic [1:0] AM_BLT = 2'h3;
  typedef enum logic [2:0] {
    VS_A16 = 3'h0, VS_A24 = 3'h1, VS_A32 = 3'h2,
    VS_CRCSR = 3'h5, VS_CUSTOM_CODE_ONE = 3'h6, VS_CUSTOM_CODE_TWO = 3'h7
  } pvtwd_space_e;
  typedef enum logic [1:0] {
    W8 = 2'h0, W16 = 2'h1, W32 = 2'h2, W64 = 2'h3
  } pvtwd_width_e;
  typedef struct packed {
    logic [31:0] addr;
    logic [3:0] cmd;
  } pvtwd_pci_s;
  typedef struct packed {
    logic [31:0] addr;
    logic [5:0] am;
    pvtwd_width_e width;
    logic block;
    logic mblt;
    logic posted;
    logic special;
    logic [2:0] win;
  } pvtwd_req_s;
endpackage

// ==== test/pvtwd_far_model.sv ====
// far-bus slave stand-in that accepts each claimed request
`timescale 1ns/1ns
`default_nettype none
module pvtwd_far_model
  import pvtwd_pkg::*;
(
  // decoder side
  input wire logic clk,
  input wire logic claim,
  input wire pvtwd_req_s req,
  // bench side
  output int taken
);
  // a slave sees one fully formed request per claim, never a partial one
  initial taken = 0;
  always @(posedge clk) begin
    #1;
    if (claim === 1'b1 && !$isunknown(req)) begin
      taken = taken + 1;
    end
  end
endmodule
`default_nettype wire

// ==== test/test_pci_to_vme_target_window_decode.sv ====
// self-checking bench for the pci target window decoder
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin bad_count++; \
  $display("ERROR %0t: got %h want %h", $time, a, b); end end
module test_pci_to_vme_target_window_decode;
  import pvtwd_pkg::*;
  typedef struct packed {logic miss; pvtwd_req_s req;} pvtwd_note_s;
  localparam logic [5:0] CU_ONE = 6'h1d;
  localparam logic [5:0] CU_TWO = 6'h12;
  logic MCLK = 0, RESET_N = 0, ADDR_VALID = 0, DATA_VALID = 0, DATA_IS64 = 0, DATA_LAST = 0;
  logic REG_WR = 0, CLAIM, MISS, SPLIT16;
  logic [7:0] DATA_BE_N = 8'hff;
  logic [5:0] REG_IDX = 6'h00;
  logic [31:0] REG_WDATA = 32'h0, REG_RDATA, c, a;
  pvtwd_pci_s PCI_ADDR = '0;
  pvtwd_req_s REQ, last_exp = '0, m;
  pvtwd_note_s notes[$];
  pvtwd_note_s nt, got;
  int bad_count = 0, n_tests = 0, taken, n_claim = 0;
  pvtwd_space_e sp_tab[6] = '{VS_A16, VS_A24, VS_A32, VS_CRCSR, VS_CUSTOM_CODE_ONE, VS_CUSTOM_CODE_TWO};

  pvtwd_decode i_pvtwd_decode (.MCLK(MCLK), .RESET_N(RESET_N), .ADDR_VALID(ADDR_VALID),
    .PCI_ADDR(PCI_ADDR), .DATA_VALID(DATA_VALID), .DATA_BE_N(DATA_BE_N),
    .DATA_IS64(DATA_IS64), .DATA_LAST(DATA_LAST), .REG_WR(REG_WR), .REG_IDX(REG_IDX),
    .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .CLAIM(CLAIM), .MISS(MISS), .REQ(REQ),
    .SPLIT16(SPLIT16));
  pvtwd_far_model i_pvtwd_far_model (.clk(MCLK), .claim(CLAIM), .req(REQ), .taken(taken));

  initial begin
    forever #20 MCLK = ~MCLK;
  end

  task automatic complete_run();
    if (bad_count == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // inputs always move 1ns after the rising edge
  task automatic step();
    @(posedge MCLK);
    #1;
  endtask

  task automatic wr(input logic [5:0] idx, input logic [31:0] d);
    REG_IDX = idx;
    REG_WDATA = d;
    REG_WR = 1'b1;
    step();
    REG_WR = 1'b0;
    step();
  endtask

  task automatic rd(input logic [5:0] idx, input logic [31:0] e);
    REG_IDX = idx;
    step();
    `CHK(REG_RDATA, e)
  endtask

  // control word: enable set, flags are program, supervisor, block
  function automatic logic [31:0] ctl(input logic p, input logic [1:0] wd,
      input logic [2:0] sp, input logic [2:0] f, input logic io);
    return {2'b11 & {1'b1, p}, 6'h00, wd, 3'h0, sp, 1'b0, f[2], 1'b0, f[1], 3'h0, f[0],
      7'h00, io};
  endfunction

  function automatic pvtwd_req_s exp_std(input logic [31:0] k, input logic [31:0] ta,
      input logic [2:0] w, input logic wrt);
    pvtwd_req_s r;
    pvtwd_space_e s;
    logic big;
    logic [1:0] lo;
    s = pvtwd_space_e'(k[CTL_FAR_LO +: 3]);
    big = (s == VS_A24) || (s == VS_A32);
    r = '0;
    r.addr = ta;
    r.win = w;
    r.width = pvtwd_width_e'(k[CTL_WIDTH_LO +: 2]);
    r.mblt = big && r.width == W64;
    r.block = big && r.width != W64 && k[CTL_BLOCK];
    r.posted = wrt && k[CTL_POST] && !k[CTL_NEAR_IO];
    lo = r.mblt ? AM_MBLT : (r.block ? AM_BLT : (k[CTL_PROG] ? AM_PROG : AM_DATA));
    case (s)
      VS_A32: r.am = {AM_A32_HI, k[CTL_SUPER], lo};
      VS_A24: r.am = {AM_A24_HI, k[CTL_SUPER], lo};
      VS_A16: r.am = {AM_A16_HI, k[CTL_SUPER], AM_DATA};
      VS_CRCSR: r.am = AM_CRCSR;
      default: begin
        r.am = (s == VS_CUSTOM_CODE_ONE) ? CU_ONE : CU_TWO;
        r.width = W32;
      end
    endcase
    return r;
  endfunction

  function automatic pvtwd_req_s fx(input logic [31:0] ta, input logic [5:0] am,
      input pvtwd_width_e w, input logic p);
    pvtwd_req_s r;
    r = '0;
    r.addr = ta;
    r.am = am;
    r.width = w;
    r.posted = p;
    r.special = 1'b1;
    return r;
  endfunction

  // one address phase plus nb beats; 64-bit beats are marked by a live upper half
  task automatic xfer(input logic [31:0] ad, input logic [3:0] cmd, input logic ms,
      input pvtwd_req_s e, input int nb, input logic [7:0] b1, input logic [7:0] b2,
      input logic sp);
    nt.miss = ms;
    nt.req = ms ? last_exp : e;
    notes.push_back(nt);
    if (!ms) begin
      last_exp = e;
      n_claim++;
    end
    PCI_ADDR = {ad, cmd};
    ADDR_VALID = 1'b1;
    step();
    ADDR_VALID = 1'b0;
    `CHK(CLAIM ^ MISS, 1'b1)
    for (int i = 0; i < nb; i++) begin
      DATA_VALID = 1'b1;
      DATA_BE_N = (i == 0) ? b1 : b2;
      DATA_IS64 = b1[7:4] != 4'hf;
      DATA_LAST = i == nb - 1;
      step();
    end
    DATA_VALID = 1'b0;
    DATA_LAST = 1'b0;
    if (nb > 0) `CHK(SPLIT16, sp)
    step();
  endtask

  task automatic miss_at(input logic [31:0] ad, input logic [3:0] cmd);
    xfer(ad, cmd, 1'b1, '0, 0, 8'hff, 8'hff, 1'b0);
  endtask

  // watcher: each claim or miss takes the oldest note; a miss keeps the old request
  always @(negedge MCLK) begin
    if (CLAIM === 1'b1 || MISS === 1'b1) begin
      if (notes.size() == 0) begin
        bad_count++;
        $display("ERROR %0t: decode result with nothing pending", $time);
      end else begin
        got = notes.pop_front();
        m = '0;
        m.win = got.req.special ? 3'h7 : 3'h0;
        `CHK({CLAIM, MISS}, {~got.miss, got.miss})
        `CHK(REQ | m, got.req | m)
      end
    end
  end

  initial begin
    repeat (20000) @(posedge MCLK);
    bad_count++;
    $display("ERROR %0t: run hung", $time);
    complete_run();
  end

  initial begin
    void'($urandom(74));
    repeat (10) @(posedge MCLK);
    #1;
    RESET_N = 1'b1;
    rd(IDX_CUSTOM, 32'h0000_1010);
    rd(IDX_CTRL, REG_RST);
    wr(IDX_CUSTOM, 32'h0000_3f3f);
    rd(IDX_CUSTOM, 32'h0000_1f1f);
    wr(IDX_CUSTOM, {18'h0, CU_ONE, 2'h0, CU_TWO});
    // window 0, fine grain, offset sum wraps past the top
    wr(IDX_BASE, 32'h1000_0000);
    wr(IDX_LIMIT, 32'h1000_2000);
    wr(IDX_OFFSET, 32'hf000_3abc);
    miss_at(32'h1000_0010, CMD_MEM_RD);
    c = ctl(1'b0, W32, VS_A32, 3'h0, 1'b0);
    wr(IDX_CTRL, c);
    xfer(32'h1000_1ff0, CMD_MEM_RD, 0, exp_std(c, 32'h0000_4ff0, 3'h0, 0), 0, 0, 0, 0);
    miss_at(32'h1000_2000, CMD_MEM_RD);
    miss_at(32'h0fff_f000, CMD_MEM_WR);
    miss_at(32'h1000_1000, CMD_IO_RD);
    // window 1, coarse grain, every far space plus random attributes
    wr(6'h04, 32'h2000_8000);
    wr(6'h05, 32'h2010_0000);
    wr(6'h06, 32'h0003_1234);
    for (int i = 0; i < 24; i++) begin
      c = ctl(1'($urandom), 2'($urandom), sp_tab[i % 6], 3'($urandom), 1'b0);
      a = 32'h2000_0000 + ($urandom & 32'h000f_fffc);
      wr(6'h07, c);
      xfer(a, CMD_MEM_WR, 0, exp_std(c, a + 32'h0003_0000, 3'h1, 1), 0, 0, 0, 0);
    end
    // window 2, posted 32-bit memory window for halfword splitting
    wr(6'h08, 32'h3000_0000);
    wr(6'h09, 32'h3001_0000);
    c = ctl(1'b1, W32, VS_A32, 3'h0, 1'b0);
    wr(6'h0b, c);
    xfer(32'h3000_0000, CMD_MEM_WR, 0, exp_std(c, 32'h3000_0000, 3'h2, 1),
      2, 8'hf3, 8'hfc, 1);
    xfer(32'h3000_0004, CMD_MEM_WR, 0, exp_std(c, 32'h3000_0004, 3'h2, 1),
      2, 8'hf3, 8'hfc, 0);
    xfer(32'h3000_0010, CMD_MEM_WR, 0, exp_std(c, 32'h3000_0010, 3'h2, 1),
      2, 8'hfc, 8'hf3, 0);
    xfer(32'h3000_0008, CMD_MEM_WRI, 0, exp_std(c, 32'h3000_0008, 3'h2, 1),
      1, 8'hc3, 8'hff, 1);
    // settings change only once nothing is outstanding
    wr(6'h0b, ctl(1'b0, W8, VS_A24, 3'h1, 1'b0));
    miss_at(32'h3001_0000, CMD_MEM_WR);
    // window 3 in i/o space never posts
    wr(6'h0c, 32'h4000_0000);
    wr(6'h0d, 32'h4001_0000);
    c = ctl(1'b1, W32, VS_A32, 3'h0, 1'b1);
    wr(6'h0f, c);
    xfer(32'h4000_0000, CMD_IO_WR, 0, exp_std(c, 32'h4000_0000, 3'h3, 1),
      2, 8'hf3, 8'hfc, 0);
    miss_at(32'h4000_0000, CMD_MEM_WR);
    // fixed window at 0xa8000000, region 1 wide and program, region 2 supervisor
    wr(IDX_FIXED, 32'hc020_242a);
    xfer(32'ha9ff_fff0, CMD_MEM_WR, 0, fx(32'h0000_fff0, 6'h29, W32, 1), 0, 0, 0, 0);
    xfer(32'ha912_3450, CMD_MEM_RDM, 0, fx(32'h0012_3450, 6'h3a, W32, 0), 0, 0, 0, 0);
    xfer(32'haa00_0040, CMD_MEM_WR, 0, fx(32'h0000_0040, 6'h3d, W16, 1), 0, 0, 0, 0);
    xfer(32'ha800_0000, CMD_MEM_RDL, 0, fx(32'h0000_0000, 6'h39, W16, 0), 0, 0, 0, 0);
    miss_at(32'hac00_0000, CMD_MEM_RD);
    miss_at(32'ha800_0000, CMD_IO_RD);
    wr(IDX_FIXED, 32'h4020_242a);
    miss_at(32'ha800_0000, CMD_MEM_WR);
    for (int i = 0; i < 20 && notes.size() > 0; i++) step();
    `CHK(notes.size(), 0)
    `CHK(taken, n_claim)
    // status: idle tracker, last capture from the fixed window, not posted
    rd(IDX_STATUS, 32'h0000_0020);
    complete_run();
  end
endmodule
`default_nettype wire
